// ### rtl/sync_sel_pkg.sv
// Overview of operation
// - Two selections: system clock, sync output
// - Each input has quality and priority, duplicate priorities flagged
// - Choose from defect, quality, priority automatically
// - Best quality group, then highest priority
// - Upstream fail forces do-not-use quality
// - Distribute selected timing as clock plus frame start
// - Sink all-ones clocked by input clock
// - Path all-ones on matching path clock
// - Section all-ones on 20 ppm oscillator
// - Rate oscillators 15 to 100 ppm
// - Internal oscillator is a selectable candidate
package sync_sel_pkg;
	// ****************************************
	// Widths and codes
	// ****************************************
	localparam int          QL_W               = 4;        // Quality code width
	localparam int          PRIO_W             = 4;        // Priority width, lower value wins
	localparam logic [3:0]  QUALITY_DO_NOT_USE = 4'hf;     // Do-not-use quality code
	localparam logic [3:0]  OSC_QL_DEF         = 4'hb;     // Internal oscillator quality
	localparam logic [3:0]  OSC_PRIO_DEF       = 4'hf;     // Internal oscillator priority
	localparam int          NUM_REFS_DEF       = 4;        // External reference inputs
	localparam int          NUM_TU_DEF         = 4;        // Lower-order path lanes

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_KHZ            = 20000;    // Master clock rate
	localparam int          FRAME_TIME_US      = 125;      // Frame period
	localparam int          REF_RATE_KHZ       = 2048;     // Reference clock rate
	localparam int          FRAME_CLKS         = FRAME_TIME_US * REF_RATE_KHZ / 1000;
	localparam int          OSC_HALF_US_X1000  = 244;      // Internal osc half period, ns
	localparam int          OSC_HALF_CLKS      = (OSC_HALF_US_X1000 + 49) / 50;

	// ****************************************
	// Alarm oscillators, octet rates in kHz
	// ****************************************
	localparam int          NUM_PDH_OSC        = 5;
	localparam int          MS_AIS_TOL_PPM     = 20;
	localparam int          MS_AIS_OCTET_KHZ   = 19440;
	localparam int          PDH_TOL_PPM [5]    = '{15, 20, 30, 50, 100};
	localparam int          PDH_OCTET_KHZ [5]  = '{17408, 4296, 1056, 256, 8};

	// ****************************************
	// Candidate carrier
	// ****************************************
	typedef struct packed {
		logic              defect;   // Defect present
		logic [QL_W-1:0]   quality;  // Effective quality code
		logic [PRIO_W-1:0] prio;     // Configured priority
	} cand_t;
endpackage

// ### rtl/ref_picker.sv
`timescale 1ns/100ps
// ****************************************
// Quality-then-priority picker
// ****************************************
module ref_picker #(
	parameter int NC    = 5,
	parameter int IDX_W = 3
) (
	// Clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        rst_i,
	// Candidates
	input  wire sync_sel_pkg::cand_t [NC-1:0] cand_i,
	input  wire logic [NC-1:0]               allow_i,
	// Choice
	output logic [IDX_W-1:0]                 sel_o,
	output logic                             valid_o
);
	import sync_sel_pkg::*;

	logic [IDX_W-1:0] nxt_sel;   // Combinational winner
	logic             nxt_valid; // Any eligible candidate
	logic [QL_W+PRIO_W-1:0] best_key;
	logic [IDX_W-1:0] sel_ff;
	logic             valid_ff;

	if (NC < 1 || NC > (1 << IDX_W)) begin : g_chk
		$error("ref_picker: index width too small");
	end

	// Scan: smallest quality code first, then smallest priority
	always_comb begin
		nxt_sel   = '0;
		nxt_valid = 1'b0;
		best_key  = '1;
		for (int i = 0; i < NC; i++) begin
			if (allow_i[i] && !cand_i[i].defect && cand_i[i].quality != QUALITY_DO_NOT_USE) begin
				if (!nxt_valid || {cand_i[i].quality, cand_i[i].prio} < best_key) begin
					best_key  = {cand_i[i].quality, cand_i[i].prio};
					nxt_sel   = IDX_W'(i);
					nxt_valid = 1'b1;
				end
			end
		end
	end

	// Registered choice, refreshed every cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_ff   <= '0;
			valid_ff <= 1'b0;
		end else begin
			sel_ff   <= nxt_sel;
			valid_ff <= nxt_valid;
		end
	end

	assign sel_o   = sel_ff;
	assign valid_o = valid_ff;
endmodule

// ### rtl/sync_reference_selector.sv
`timescale 1ns/100ps
// ****************************************
// Synchronization reference selector
// ****************************************
module sync_reference_selector #(
	parameter int          NUM_REFS = sync_sel_pkg::NUM_REFS_DEF,
	parameter int          NUM_TU   = sync_sel_pkg::NUM_TU_DEF,
	parameter logic [3:0]  OSC_QL   = sync_sel_pkg::OSC_QL_DEF,
	parameter logic [3:0]  OSC_PRIO = sync_sel_pkg::OSC_PRIO_DEF
) (
	// Clock and reset
	input  wire logic                            mclk_i,
	input  wire logic                            rst_i,
	// Reference inputs
	input  wire logic [NUM_REFS-1:0]             ref_clk_i,
	input  wire logic [NUM_REFS-1:0]             ref_defect_i,
	input  wire logic [NUM_REFS-1:0]             upstream_fail_flag_i,
	input  wire logic [NUM_REFS*4-1:0]           sync_quality_message_i,
	input  wire logic [NUM_REFS*4-1:0]           ref_prio_i,
	input  wire logic [NUM_REFS:0]               sys_allow_i,
	input  wire logic [NUM_REFS:0]               out_allow_i,
	// Selection status
	output logic [$clog2(NUM_REFS+1)-1:0]        sys_sel_o,
	output logic                                 sys_valid_o,
	output logic [$clog2(NUM_REFS+1)-1:0]        out_sel_o,
	output logic                                 out_valid_o,
	output logic                                 prio_clash_o,
	// Distributed timing
	output logic                                 dist_timing_clock_o,
	output logic                                 dist_frame_start_o,
	output logic                                 sync_out_clock_o,
	// Sink alarm insertion
	input  wire logic                            sink_input_clock_i,
	input  wire logic                            sink_data_i,
	input  wire logic                            sink_ais_en_i,
	output logic                                 sink_data_o,
	// Source path alarm insertion
	input  wire logic                            high_order_path_clock_i,
	input  wire logic                            au_data_i,
	input  wire logic                            au_ais_en_i,
	output logic                                 au_data_o,
	input  wire logic [NUM_TU-1:0]               low_order_path_clock_i,
	input  wire logic [NUM_TU-1:0]               tu_data_i,
	input  wire logic [NUM_TU-1:0]               tu_ais_en_i,
	output logic [NUM_TU-1:0]                    tu_data_o,
	// Alarm oscillator octet ticks
	output logic                                 ms_ais_tick_o,
	output logic [sync_sel_pkg::NUM_PDH_OSC-1:0] pdh_ais_tick_o
);
	import sync_sel_pkg::*;

	localparam int NC    = NUM_REFS + 1;       // Externals plus internal oscillator
	localparam int IDX_W = $clog2(NUM_REFS + 1);

	if (NUM_REFS < 1 || NUM_TU < 1) begin : g_chk
		$error("sync_reference_selector: need at least one reference and lane");
	end

	// ****************************************
	// Quality conditioning
	// ****************************************
	// Server fail overrides received quality
	function automatic logic [3:0] eff_quality(input logic fail, input logic [3:0] ql);
		eff_quality = fail ? QUALITY_DO_NOT_USE : ql;
	endfunction

	cand_t [NC-1:0]   cand;          // Candidate table
	logic  [NC-1:0]   osc_level;     // Candidate clock levels
	logic             osc_ff;        // Internal oscillator level
	logic [15:0]      osc_cnt_ff;    // Internal oscillator divider

	for (genvar i = 0; i < NUM_REFS; i++) begin : g_cand
		assign cand[i].defect  = ref_defect_i[i];
		assign cand[i].quality = eff_quality(upstream_fail_flag_i[i], sync_quality_message_i[i*4 +: 4]);
		assign cand[i].prio    = ref_prio_i[i*4 +: 4];
		assign osc_level[i]    = ref_clk_i[i];
	end
	// Internal oscillator sits at the last index
	assign cand[NUM_REFS].defect  = 1'b0;
	assign cand[NUM_REFS].quality = OSC_QL;
	assign cand[NUM_REFS].prio    = OSC_PRIO;
	assign osc_level[NUM_REFS]    = osc_ff;

	// ****************************************
	// Internal oscillator
	// ****************************************
	// Free-running divider from the master clock
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_cnt_ff <= '0;
			osc_ff     <= 1'b0;
		end else if (osc_cnt_ff == 16'(OSC_HALF_CLKS - 1)) begin
			osc_cnt_ff <= '0;
			osc_ff     <= ~osc_ff;
		end else begin
			osc_cnt_ff <= osc_cnt_ff + 16'h0001;
		end
	end

	// ****************************************
	// Duplicate priority watch
	// ****************************************
	logic nxt_clash;     // Two candidates share a priority
	logic clash_ff;

	// Ties are broken by lowest index, flagged here
	always_comb begin
		nxt_clash = 1'b0;
		for (int a = 0; a < NC; a++) begin
			for (int b = a + 1; b < NC; b++) begin
				if (cand[a].prio == cand[b].prio) begin
					nxt_clash = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			clash_ff <= 1'b0;
		end else begin
			clash_ff <= nxt_clash;
		end
	end
	assign prio_clash_o = clash_ff;

	// ****************************************
	// Two selections
	// ****************************************
	ref_picker #(.NC(NC), .IDX_W(IDX_W)) u_sys_pick (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.cand_i  (cand),
		.allow_i (sys_allow_i),
		.sel_o   (sys_sel_o),
		.valid_o (sys_valid_o)
	);

	ref_picker #(.NC(NC), .IDX_W(IDX_W)) u_out_pick (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.cand_i  (cand),
		.allow_i (out_allow_i),
		.sel_o   (out_sel_o),
		.valid_o (out_valid_o)
	);

	// ****************************************
	// Timing distribution
	// ****************************************
	logic        tck_ff;      // Distributed clock
	logic        tck_d_ff;    // Previous level for edge detect
	logic        fs_ff;       // Frame start pulse
	logic [15:0] fcnt_ff;     // Clock edges within frame
	logic        sout_ff;     // Sync output clock
	logic        tck_rise;

	// Re-time the chosen reference; with no valid choice the dist clock takes the internal oscillator, the sync output holds low
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tck_ff   <= 1'b0;
			tck_d_ff <= 1'b0;
			sout_ff  <= 1'b0;
		end else begin
			tck_ff   <= sys_valid_o ? osc_level[sys_sel_o] : osc_ff;
			tck_d_ff <= tck_ff;
			sout_ff  <= out_valid_o & osc_level[out_sel_o];
		end
	end
	assign tck_rise = tck_ff & ~tck_d_ff;

	// Frame start once per frame of distributed clock edges
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			fcnt_ff <= '0;
			fs_ff   <= 1'b0;
		end else begin
			fs_ff <= 1'b0;
			if (tck_rise) begin
				if (fcnt_ff == 16'(FRAME_CLKS - 1)) begin
					fcnt_ff <= '0;
					fs_ff   <= 1'b1;
				end else begin
					fcnt_ff <= fcnt_ff + 16'h0001;
				end
			end
		end
	end

	assign dist_timing_clock_o = tck_ff;
	assign dist_frame_start_o  = fs_ff;
	assign sync_out_clock_o    = sout_ff;

	// ****************************************
	// All-ones insertion on path clocks
	// ****************************************
	logic              sk_d_ff;   // Sink clock previous level
	logic              sk_q_ff;   // Sink data out
	logic              ho_d_ff;   // High-order clock previous
	logic              au_q_ff;   // AU data out
	logic [NUM_TU-1:0] lo_d_ff;   // Low-order clocks previous
	logic [NUM_TU-1:0] tu_q_ff;   // TU data out

	// Sink side updates on input clock edges
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sk_d_ff <= 1'b0;
			sk_q_ff <= 1'b1;
		end else begin
			sk_d_ff <= sink_input_clock_i;
			if (sink_input_clock_i && !sk_d_ff) begin
				sk_q_ff <= sink_ais_en_i | sink_data_i;
			end
		end
	end
	assign sink_data_o = sk_q_ff;

	// AU side updates on high-order path clock edges
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ho_d_ff <= 1'b0;
			au_q_ff <= 1'b1;
		end else begin
			ho_d_ff <= high_order_path_clock_i;
			if (high_order_path_clock_i && !ho_d_ff) begin
				au_q_ff <= au_ais_en_i | au_data_i;
			end
		end
	end
	assign au_data_o = au_q_ff;

	// Each TU lane on its own lower-order clock
	for (genvar t = 0; t < NUM_TU; t++) begin : g_tu
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				lo_d_ff[t] <= 1'b0;
				tu_q_ff[t] <= 1'b1;
			end else begin
				lo_d_ff[t] <= low_order_path_clock_i[t];
				if (low_order_path_clock_i[t] && !lo_d_ff[t]) begin
					tu_q_ff[t] <= tu_ais_en_i[t] | tu_data_i[t];
				end
			end
		end
	end
	assign tu_data_o = tu_q_ff;

	// ****************************************
	// Alarm oscillators
	// ****************************************
	// 32-bit accumulators; step error far below the ppm budgets
	localparam logic [31:0] MS_INC = 32'((64'(MS_AIS_OCTET_KHZ) << 32) / CLK_KHZ);
	logic [32:0] ms_acc_ff;
	logic        ms_tick_ff;

	if (MS_AIS_OCTET_KHZ >= CLK_KHZ || MS_AIS_TOL_PPM < 1) begin : g_ms_chk
		$error("sync_reference_selector: section alarm rate not servable");
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ms_acc_ff  <= '0;
			ms_tick_ff <= 1'b0;
		end else begin
			ms_acc_ff  <= {1'b0, ms_acc_ff[31:0]} + {1'b0, MS_INC};
			ms_tick_ff <= ms_acc_ff[32];
		end
	end
	assign ms_ais_tick_o = ms_tick_ff;

	for (genvar p = 0; p < NUM_PDH_OSC; p++) begin : g_pdh
		localparam logic [31:0] P_INC = 32'((64'(PDH_OCTET_KHZ[p]) << 32) / CLK_KHZ);
		logic [32:0] acc_ff;
		logic        tick_ff;
		if (PDH_OCTET_KHZ[p] >= CLK_KHZ || PDH_TOL_PPM[p] < 1) begin : g_chk
			$error("sync_reference_selector: alarm rate not servable");
		end
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				acc_ff  <= '0;
				tick_ff <= 1'b0;
			end else begin
				acc_ff  <= {1'b0, acc_ff[31:0]} + {1'b0, P_INC};
				tick_ff <= acc_ff[32];
			end
		end
		assign pdh_ais_tick_o[p] = tick_ff;
	end
endmodule

// ### sim/sync_sel_checker.sv
`timescale 1ns/100ps
// ****************************************
// Port checker for the reference selector
// ****************************************
module sync_sel_checker #(
	parameter int NUM_REFS = 4,
	parameter int NUM_TU   = 4
) (
	// Clock and reset
	input wire logic                            mclk_i,
	input wire logic                            rst_i,
	// Selection pins
	input wire logic [NUM_REFS-1:0]             ref_defect_i,
	input wire logic [NUM_REFS-1:0]             upstream_fail_flag_i,
	input wire logic [NUM_REFS:0]               sys_allow_i,
	input wire logic [$clog2(NUM_REFS+1)-1:0]   sys_sel_o,
	input wire logic                            sys_valid_o,
	input wire logic                            out_valid_o,
	input wire logic                            sync_out_clock_o,
	input wire logic                            dist_timing_clock_o,
	input wire logic                            dist_frame_start_o,
	// Alarm insertion pins
	input wire logic                            sink_input_clock_i,
	input wire logic                            sink_data_i,
	input wire logic                            sink_ais_en_i,
	input wire logic                            sink_data_o,
	input wire logic                            high_order_path_clock_i,
	input wire logic                            au_data_i,
	input wire logic                            au_ais_en_i,
	input wire logic                            au_data_o,
	input wire logic [NUM_TU-1:0]               low_order_path_clock_i,
	input wire logic [NUM_TU-1:0]               tu_data_i,
	input wire logic [NUM_TU-1:0]               tu_ais_en_i,
	input wire logic [NUM_TU-1:0]               tu_data_o,
	input wire logic [sync_sel_pkg::NUM_PDH_OSC-1:0] pdh_ais_tick_o
);
	logic [9:0] rise_cnt_ff;  // Dist clock rises since frame start
	logic       seen_ff;      // A full frame is being counted

	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Count distributed clock rises per frame
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rise_cnt_ff <= 10'h0;
			seen_ff     <= 1'b0;
		end else if (dist_frame_start_o) begin
			rise_cnt_ff <= 10'h0;
			seen_ff     <= 1'b1;
		end else if ($rose(dist_timing_clock_o)) begin
			rise_cnt_ff <= rise_cnt_ff + 10'h1;
		end
	end

	a_frame_length: assert property (
		dist_frame_start_o && seen_ff |-> rise_cnt_ff == 10'h100) else $error("frame length wrong");
	a_frame_pulse: assert property (
		dist_frame_start_o |=> !dist_frame_start_o) else $error("frame start too wide");
	a_fail_excluded: assert property (
		$past(upstream_fail_flag_i[2]) |-> !(sys_valid_o && sys_sel_o == 3'h2)) else $error("failed input chosen");
	a_defect_excluded: assert property (
		$past(ref_defect_i[1]) |-> !(sys_valid_o && sys_sel_o == 3'h1)) else $error("defective input chosen");
	a_osc_fallback: assert property (
		$past(sys_allow_i) == 5'h10 |-> sys_valid_o && sys_sel_o == 3'h4) else $error("oscillator not chosen");
	a_out_idle_low: assert property (
		!out_valid_o |=> !sync_out_clock_o) else $error("sync output not idle");
	a_sink_ais_ones: assert property ($rose(sink_input_clock_i) |=>
		sink_data_o == ($past(sink_ais_en_i) | $past(sink_data_i))) else $error("sink data wrong");
	a_au_ais_ones: assert property ($rose(high_order_path_clock_i) |=>
		au_data_o == ($past(au_ais_en_i) | $past(au_data_i))) else $error("au data wrong");
	a_tu_ais_ones: assert property ($rose(low_order_path_clock_i[0]) |=>
		tu_data_o[0] == ($past(tu_ais_en_i[0]) | $past(tu_data_i[0]))) else $error("tu data wrong");
	a_pdh_tick_gap: assert property (pdh_ais_tick_o[3] |=>
		!pdh_ais_tick_o[3] [*8] ##[69:71] pdh_ais_tick_o[3]) else $error("tick spacing wrong");
endmodule

bind sync_reference_selector sync_sel_checker #(.NUM_REFS(NUM_REFS), .NUM_TU(NUM_TU)) chk_i (.*);

// ### sim/timing_consumer.sv
`timescale 1ns/100ps
// ****************************************
// Downstream elastic store reader model
// ****************************************
module timing_consumer (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// Timing bundle
	input  wire logic       clk_i,
	input  wire logic       fs_i,
	// Observed counts
	output logic [9:0]      frame_len_o,
	output logic [3:0]      frames_o
);
	logic       clk_ff;     // Previous clock sample
	logic [9:0] rd_cnt_ff;  // Reads in current frame

	// Read one octet per clock rise, restart at frame start
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_ff      <= 1'b0;
			rd_cnt_ff   <= 10'h0;
			frame_len_o <= 10'h0;
			frames_o    <= 4'h0;
		end else begin
			clk_ff <= clk_i;
			if (fs_i) begin
				frame_len_o <= rd_cnt_ff;
				rd_cnt_ff   <= 10'h0;
				frames_o    <= frames_o + 4'h1;
			end else if (clk_i && !clk_ff) begin
				rd_cnt_ff <= rd_cnt_ff + 10'h1;
			end
		end
	end
endmodule

// ### sim/test_sync_reference_selector.sv
`timescale 1ns/100ps
module test_sync_reference_selector;
	import sync_sel_pkg::*;
	logic        mclk_i  = 1'b0;
	logic        rst_i   = 1'b1;
	logic        rclk    = 1'b0;      // Shared reference and path clock
	logic [3:0]  defect  = 4'h0;
	logic [3:0]  fail    = 4'h0;
	logic [15:0] qual    = 16'h4224;
	logic [15:0] prio    = 16'h2130;
	logic [4:0]  s_allow = 5'h1f;
	logic [4:0]  o_allow = 5'h1f;
	logic        dat     = 1'b0;      // Data into all alarm paths
	logic        ais     = 1'b0;      // Alarm enable for all paths
	logic        cnt_en  = 1'b0;
	logic [2:0]  s_sel, o_sel;
	logic        s_val, o_val, clash, dclk, dfs, sclk, sk_o, au_o, ms_tick;
	logic [3:0]  tu_o, frames;
	logic [4:0]  pdh_tick;
	logic [9:0]  f_len;
	int          tick_cnt [6] = '{0, 0, 0, 0, 0, 0};
	int          bad_count = 0;
	int          checks_done = 0;

	sync_reference_selector uut (.mclk_i(mclk_i), .rst_i(rst_i), .ref_clk_i({4{rclk}}),
		.ref_defect_i(defect), .upstream_fail_flag_i(fail), .sync_quality_message_i(qual),
		.ref_prio_i(prio), .sys_allow_i(s_allow), .out_allow_i(o_allow), .sys_sel_o(s_sel),
		.sys_valid_o(s_val), .out_sel_o(o_sel), .out_valid_o(o_val), .prio_clash_o(clash),
		.dist_timing_clock_o(dclk), .dist_frame_start_o(dfs), .sync_out_clock_o(sclk),
		.sink_input_clock_i(rclk), .sink_data_i(dat), .sink_ais_en_i(ais), .sink_data_o(sk_o),
		.high_order_path_clock_i(rclk), .au_data_i(dat), .au_ais_en_i(ais), .au_data_o(au_o),
		.low_order_path_clock_i({4{rclk}}), .tu_data_i({4{dat}}), .tu_ais_en_i({4{ais}}),
		.tu_data_o(tu_o), .ms_ais_tick_o(ms_tick), .pdh_ais_tick_o(pdh_tick));
	timing_consumer far_i (.mclk_i(mclk_i), .rst_i(rst_i), .clk_i(dclk), .fs_i(dfs),
		.frame_len_o(f_len), .frames_o(frames));

	always #25 mclk_i = ~mclk_i;
	// Reference clock, 12 master cycles a period
	always begin
		repeat (6) @(posedge mclk_i);
		#1 rclk = ~rclk;
	end
	// Tick counters for the alarm oscillators
	always @(posedge mclk_i) begin
		if (cnt_en) begin
			for (int i = 0; i < 5; i++) tick_cnt[i] += pdh_tick[i];
			tick_cnt[5] += ms_tick;
		end
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic t_rank();
		cyc(3);
		chk("sys_sel", 16'h2, s_sel);
		chk("clash", 16'h0, clash);
		fail = 4'h4;
		cyc(3);
		chk("sys_sel", 16'h1, s_sel);
		defect = 4'h2;
		cyc(3);
		chk("sys_sel", 16'h0, s_sel);
		qual = 16'h1224;
		cyc(3);
		chk("sys_sel", 16'h3, s_sel);
		prio = 16'h2100;
		cyc(3);
		chk("clash", 16'h1, clash);
		prio = 16'h2130;
	endtask
	task automatic t_dual();
		logic s0;
		o_allow = 5'h01;
		cyc(3);
		chk("out_sel", 16'h0, o_sel);
		chk("sys_sel", 16'h3, s_sel);
		// Reference flips once every 6 cycles, so the output must follow
		s0 = sclk;
		cyc(6);
		chk("sync_out toggle", {15'h0, ~s0}, {15'h0, sclk});
		o_allow = 5'h00;
		cyc(3);
		chk("out_valid", 16'h0, o_val);
		chk("sync_out", 16'h0, sclk);
		o_allow = 5'h1f;
	endtask
	task automatic t_osc();
		s_allow = 5'h10;
		cyc(3);
		chk("sys_sel", 16'h4, s_sel);
		chk("sys_valid", 16'h1, s_val);
		s_allow = 5'h1f;
	endtask
	task automatic t_ais();
		cyc(30);
		chk("alarm paths clear", 16'h0, {sk_o, au_o, tu_o});
		ais = 1'b1;
		cyc(30);
		chk("alarm paths ones", 16'h3f, {sk_o, au_o, tu_o});
		ais = 1'b0;
		// Data must pass untouched when no alarm is forced
		dat = 1'b1;
		cyc(30);
		chk("alarm paths data", 16'h3f, {sk_o, au_o, tu_o});
		dat = 1'b0;
		cyc(30);
		chk("alarm paths clear again", 16'h0, {sk_o, au_o, tu_o});
	endtask
	task automatic t_ticks();
		int e;
		int g;
		cnt_en = 1'b1;
		cyc(10000);
		cnt_en = 1'b0;
		for (int i = 0; i < 6; i++) begin
			e = (i < 5) ? PDH_OCTET_KHZ[i] / 2 : MS_AIS_OCTET_KHZ / 2;
			g = (tick_cnt[i] >= e - 1 && tick_cnt[i] <= e + 1) ? e : tick_cnt[i];
			chk("alarm ticks", e[15:0], g[15:0]);
		end
	endtask
	task automatic t_dist();
		logic [3:0] n0;
		n0 = frames;
		for (int i = 0; i < 8000 && frames != n0 + 4'h2; i++) cyc(1);
		chk("frames seen", {12'h0, n0 + 4'h2}, {12'h0, frames});
		chk("frame length", 16'h100, {6'h0, f_len});
	endtask

	task final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		cyc(10);
		rst_i = 1'b0;
		t_rank();
		t_dual();
		t_osc();
		t_ais();
		t_ticks();
		t_dist();
		final_report();
	end
	// Watchdog, about 60000 cycles
	initial begin
		#3000000;
		bad_count++;
		final_report();
	end
endmodule
